// ===== autoneg_page_aux_regs.sv
// Auto-negotiation expansion, next page and 100BASE-TX aux control register bank
`timescale 1ns/10ps
`default_nettype none
`include "autoneg_regs_cfg.svh"

// Behaviour
// R01: Expansion bit 4 latches parallel detection fault; cleared by reading or reset.
// R02: Expansion bit 3 mirrors partner ability bit 15, partner next page capable.
// R03: Expansion bit 2 reads constant one; local device always next page capable.
// R04: Expansion bit 1 latches on received checked page; cleared by read or reset.
// R05: Expansion bit 0 reads one only once partner known to negotiate.
// R06: Expansion bits 15 to 5 read zero and ignore writes.
// R07: Software sets outgoing bit 15 when more pages follow; device sends it.
// R08: Outgoing page at 0x07 writable except toggle; resets to 0x2001.
// R09: Outgoing bit 12 means local can comply; bit 13 selects message page.
// R10: Toggle bit read-only, kept by arbitration to stay in step with partner.
// R11: Register 0x08 read-only, reset zero, holds last received partner page.
// R12: Received page bit 12 shows partner able to comply with message.
// R13: Aux bit 7 bypasses alignment; with codec bypass puts raw 5B on MII.
// R14: Aux bit 5 enables far-end fault detection; reset leaves it off.
// R15: Aux bit 2 enables extended elastic FIFO running at partner speed.
// R16: Aux bit 1 enables reduced MII out-of-band signalling; reset off.
// R17: Software writes reserved aux bits as zero and ignores them on read.
// R18: Partner ability bit 15 is one when partner has next pages to send.
// R19: A latched flag set in its clearing cycle stays set.
module autoneg_page_aux_regs (
    // Clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rst_n,
    // Management register port
    input  wire autoneg_regs_pkg::reg_addr_t i_addr,
    input  wire autoneg_regs_pkg::reg_word_t i_wr_data,
    input  wire logic                        i_wr_en,
    input  wire logic                        i_rd_en,
    output var  autoneg_regs_pkg::reg_word_t o_rd_data,
    // Negotiation state machine and receive path
    input  wire logic                        i_par_det_fault,
    input  wire logic                        i_page_rx,
    input  wire autoneg_regs_pkg::reg_word_t i_page_rx_word,
    input  wire logic                        i_partner_np_capable,
    input  wire logic                        i_partner_neg_capable,
    input  wire logic                        i_np_sent,
    input  wire logic                        i_toggle_load,
    input  wire logic                        i_toggle_val,
    input  wire logic                        i_codec_bypass,
    // Page to transmit and datapath controls
    output var  autoneg_regs_pkg::reg_word_t o_np_tx_word,
    output logic                             o_raw_5b_mode,
    output logic                             o_sym_align_bypass,
    output logic                             o_far_end_fault_en,
    output logic                             o_ext_fifo_en,
    output logic                             o_reduced_mii_oob_en,
    // Interrupt
    output logic                             o_irq
);
    import autoneg_regs_pkg::*;

    logic      rst_meta_q;
    logic      rst_n_q;
    reg_word_t np_tx_q;
    reg_word_t partner_np_q;
    reg_word_t aux_ctrl_q;
    logic      pdf_q;
    logic      page_rx_q;
    logic      partner_np_q1;
    logic      neg_cap_q;
    irq_vec_t  irq_status_q;
    irq_vec_t  irq_en_q;
    irq_vec_t  irq_events;
    reg_word_t expansion;
    logic      exp_read;
    logic      wr_np_tx;
    logic      wr_aux;
    logic      wr_irq_clr;
    logic      wr_irq_en;

    // Reset release through two flops so every flop leaves reset on the same edge
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    assign exp_read   = i_rd_en && (i_addr == `OFS_EXPANSION);
    assign wr_np_tx   = i_wr_en && (i_addr == `OFS_NP_TX);
    assign wr_aux     = i_wr_en && (i_addr == `OFS_AUX_CTRL);
    assign wr_irq_clr = i_wr_en && (i_addr == `OFS_IRQ_CLEAR);
    assign wr_irq_en  = i_wr_en && (i_addr == `OFS_IRQ_ENABLE);

    // R01 fault flag latch, R19 set beats read clear
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pdf_q <= 1'b0;
        end else if (i_par_det_fault) begin
            pdf_q <= 1'b1;
        end else if (exp_read) begin
            pdf_q <= 1'b0;
        end
    end

    // R04 page received latch, R19 set beats read clear
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            page_rx_q <= 1'b0;
        end else if (i_page_rx) begin
            page_rx_q <= 1'b1;
        end else if (exp_read) begin
            page_rx_q <= 1'b0;
        end
    end

    // R02 R18 partner capability levels, sampled so reads see a stable copy
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            partner_np_q1 <= 1'b0;
            neg_cap_q     <= 1'b0;
        end else begin
            partner_np_q1 <= i_partner_np_capable;
            neg_cap_q     <= i_partner_neg_capable;
        end
    end

    // R03 R05 R06 expansion word assembly
    always_comb begin
        expansion                      = 16'h0000;
        expansion[`EXP_PDF_BIT]        = pdf_q;
        expansion[`EXP_PARTNER_NP_BIT] = partner_np_q1;
        expansion[`EXP_LOCAL_NP_BIT]   = 1'b1;
        expansion[`EXP_PAGE_RX_BIT]    = page_rx_q;
        expansion[`EXP_NEG_CAP_BIT]    = neg_cap_q;
    end

    // R07 R08 R09 outgoing page, toggle bit kept out of software reach
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            np_tx_q <= `NP_TX_RESET;
        end else begin
            if (wr_np_tx) begin
                np_tx_q[`NP_MORE_BIT:`NP_COMPLY_BIT] <= i_wr_data[`NP_MORE_BIT:`NP_COMPLY_BIT];
                np_tx_q[`NP_CODE_HI:`NP_CODE_LO]     <= i_wr_data[`NP_CODE_HI:`NP_CODE_LO];
            end
            // R10 arbitration owns toggle
            if (i_toggle_load) begin
                np_tx_q[`NP_TOGGLE_BIT] <= i_toggle_val;
            end else if (i_np_sent) begin
                np_tx_q[`NP_TOGGLE_BIT] <= ~np_tx_q[`NP_TOGGLE_BIT];
            end
        end
    end

    // R11 R12 last received partner page, whole word incl. comply bit
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            partner_np_q <= `PARTNER_NP_RESET;
        end else if (i_page_rx) begin
            partner_np_q <= i_page_rx_word;
        end
    end

    // R17 reserved bits stored as written; software keeps them zero
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aux_ctrl_q <= `AUX_CTRL_RESET;
        end else if (wr_aux) begin
            aux_ctrl_q <= i_wr_data;
        end
    end

    // Transmit page and datapath control outputs, registered from np_tx_q and the control word
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_np_tx_word         <= `NP_TX_RESET;
            o_sym_align_bypass   <= 1'b0;
            o_raw_5b_mode        <= 1'b0;
            o_far_end_fault_en   <= 1'b0;
            o_ext_fifo_en        <= 1'b0;
            o_reduced_mii_oob_en <= 1'b0;
        end else begin
            o_np_tx_word         <= np_tx_q;
            // R13 raw 5B only when both bypasses are on
            o_sym_align_bypass   <= aux_ctrl_q[`AUX_SYM_BYPASS_BIT];
            o_raw_5b_mode        <= aux_ctrl_q[`AUX_SYM_BYPASS_BIT] & i_codec_bypass;
            // R14 far-end fault detection enable
            o_far_end_fault_en   <= aux_ctrl_q[`AUX_FEF_BIT];
            // R15 extended elastic FIFO enable
            o_ext_fifo_en        <= aux_ctrl_q[`AUX_EXT_FIFO_BIT];
            // R16 reduced MII out-of-band signalling
            o_reduced_mii_oob_en <= aux_ctrl_q[`AUX_OOB_BIT];
        end
    end

    // Interrupt status: sticky, write one to clear, a fresh event wins over the clear
    always_comb begin
        irq_events                = `IRQ_RESET;
        irq_events[`IRQ_PDF_BIT]  = i_par_det_fault;
        irq_events[`IRQ_PAGE_BIT] = i_page_rx;
    end

    // R19 events survive a same-cycle clear
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_status_q <= `IRQ_RESET;
        end else if (wr_irq_clr) begin
            irq_status_q <= (irq_status_q & ~i_wr_data[1:0]) | irq_events;
        end else begin
            irq_status_q <= irq_status_q | irq_events;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_en_q <= `IRQ_RESET;
        end else if (wr_irq_en) begin
            irq_en_q <= i_wr_data[1:0];
        end
    end

    // Registered output, so the line trails the status bit by one cycle
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status_q & irq_en_q);
        end
    end

    // Read data valid only in the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_rd_data <= 16'h0000;
        end else if (i_rd_en) begin
            unique case (i_addr)
                `OFS_EXPANSION:  o_rd_data <= expansion;
                `OFS_NP_TX:      o_rd_data <= np_tx_q;
                `OFS_PARTNER_NP: o_rd_data <= partner_np_q;
                `OFS_AUX_CTRL:   o_rd_data <= aux_ctrl_q;
                `OFS_IRQ_STATUS: o_rd_data <= {14'h0000, irq_status_q};
                `OFS_IRQ_ENABLE: o_rd_data <= {14'h0000, irq_en_q};
                default:         o_rd_data <= 16'h0000;
            endcase
        end else begin
            o_rd_data <= 16'h0000;
        end
    end

    // Checks

    // R01 fault seen is reported by an expansion read in the cycle right after it
    fault_latch_a: assert property ( // R01
        @(posedge i_clock) disable iff (!rst_n_q)
        i_par_det_fault ##1 (exp_read && !i_par_det_fault)[*1]
            |-> ##1 o_rd_data[`EXP_PDF_BIT]
    ) else $error("fault flag missing on read");

    // R01 a read without new fault clears the flag
    fault_clear_a: assert property ( // R01
        @(posedge i_clock) disable iff (!rst_n_q)
        (exp_read && !i_par_det_fault) |=> !pdf_q
    ) else $error("fault flag not cleared by read");

    // R02 bit 3 follows the partner capability one cycle behind
    partner_np_mirror_a: assert property ( // R02
        @(posedge i_clock) disable iff (!rst_n_q)
        exp_read |=> (o_rd_data[`EXP_PARTNER_NP_BIT] == $past(partner_np_q1))
    ) else $error("partner next page bit mismatch");

    // R03 local capability always reads one
    local_np_one_a: assert property ( // R03
        @(posedge i_clock) disable iff (!rst_n_q)
        exp_read |=> o_rd_data[`EXP_LOCAL_NP_BIT]
    ) else $error("local next page bit not one");

    // R04 page flag holds until a read
    page_hold_a: assert property ( // R04
        @(posedge i_clock) disable iff (!rst_n_q)
        (page_rx_q && !exp_read) |=> page_rx_q
    ) else $error("page flag dropped without read");

    // R04 R11 received page lands in the partner register and flag together
    page_capture_a: assert property ( // R04
        @(posedge i_clock) disable iff (!rst_n_q)
        i_page_rx |=> (page_rx_q && partner_np_q == $past(i_page_rx_word))
    ) else $error("received page not captured");

    // R05 negotiation bit reflects the partner level two edges later
    neg_cap_read_a: assert property ( // R05
        @(posedge i_clock) disable iff (!rst_n_q)
        (!i_partner_neg_capable ##1 (exp_read && !i_partner_neg_capable))
            |=> !o_rd_data[`EXP_NEG_CAP_BIT]
    ) else $error("negotiation bit set without partner");

    // R06 reserved expansion bits are zero
    exp_reserved_a: assert property ( // R06
        @(posedge i_clock) disable iff (!rst_n_q)
        exp_read |=> (o_rd_data[`EXP_RSVD_HI:`EXP_RSVD_LO] == 11'h000)
    ) else $error("reserved expansion bits nonzero");

    // R08 R10 software write never moves the toggle bit
    toggle_write_a: assert property ( // R10
        @(posedge i_clock) disable iff (!rst_n_q)
        (wr_np_tx && !i_toggle_load && !i_np_sent)
            |=> (np_tx_q[`NP_TOGGLE_BIT] == $past(np_tx_q[`NP_TOGGLE_BIT]))
    ) else $error("toggle changed by software");

    // R07 R09 written page fields reach the transmit word two cycles later
    np_tx_write_a: assert property ( // R08
        @(posedge i_clock) disable iff (!rst_n_q)
        wr_np_tx ##1 !wr_np_tx |-> ##1
            (o_np_tx_word[`NP_MORE_BIT:`NP_COMPLY_BIT] == $past(i_wr_data[15:12], 2))
    ) else $error("next page word not transmitted");

    // R10 each sent page flips the toggle
    toggle_flip_a: assert property ( // R10
        @(posedge i_clock) disable iff (!rst_n_q)
        (i_np_sent && !i_toggle_load)
            |=> (np_tx_q[`NP_TOGGLE_BIT] != $past(np_tx_q[`NP_TOGGLE_BIT]))
    ) else $error("toggle did not flip");

    // R13 raw 5B path needs both bypass controls
    raw_mode_a: assert property ( // R13
        @(posedge i_clock) disable iff (!rst_n_q)
        o_raw_5b_mode |-> ($past(aux_ctrl_q[`AUX_SYM_BYPASS_BIT]) && $past(i_codec_bypass))
    ) else $error("raw 5B mode without both bypasses");

    // R14 R15 R16 control outputs follow the aux word one cycle behind
    aux_outputs_a: assert property ( // R14
        @(posedge i_clock) disable iff (!rst_n_q)
        ##1 (o_far_end_fault_en == $past(aux_ctrl_q[`AUX_FEF_BIT]))
            && (o_ext_fifo_en == $past(aux_ctrl_q[`AUX_EXT_FIFO_BIT]))
            && (o_reduced_mii_oob_en == $past(aux_ctrl_q[`AUX_OOB_BIT]))
    ) else $error("aux control output mismatch");

    // R19 event in the clearing cycle keeps the flag
    set_beats_clear_a: assert property ( // R19
        @(posedge i_clock) disable iff (!rst_n_q)
        (exp_read && i_page_rx) |=> page_rx_q
    ) else $error("page flag lost on same-cycle read");

    // R04 a read without a new page clears the flag
    page_clear_a: assert property ( // R04
        @(posedge i_clock) disable iff (!rst_n_q)
        (exp_read && !i_page_rx) |=> !page_rx_q
    ) else $error("page flag not cleared by read");

    // R08 code field takes the written value
    np_code_write_a: assert property ( // R08
        @(posedge i_clock) disable iff (!rst_n_q)
        wr_np_tx |=> (np_tx_q[`NP_CODE_HI:`NP_CODE_LO] == $past(i_wr_data[10:0]))
    ) else $error("next page code field not written");

    // R11 software writes never reach the received page
    partner_np_ro_a: assert property ( // R11
        @(posedge i_clock) disable iff (!rst_n_q)
        (i_wr_en && (i_addr == `OFS_PARTNER_NP) && !i_page_rx)
            |=> (partner_np_q == $past(partner_np_q))
    ) else $error("received page changed by write");

    // Read data stands only in the cycle after a read strobe
    rd_idle_zero_a: assert property (
        @(posedge i_clock) disable iff (!rst_n_q)
        !i_rd_en |=> (o_rd_data == 16'h0000)
    ) else $error("read data not zero when idle");

    // Interrupt line tracks enabled status
    irq_line_a: assert property (
        @(posedge i_clock) disable iff (!rst_n_q)
        ##1 (o_irq == |($past(irq_status_q) & $past(irq_en_q)))
    ) else $error("interrupt line mismatch");

endmodule
`default_nettype wire

// ===== autoneg_regs_cfg.svh
// Offsets, field positions, reset values for the auto-negotiation page and aux control registers
`ifndef AUTONEG_REGS_CFG_SVH
`define AUTONEG_REGS_CFG_SVH

// Register offsets on the management port
`define OFS_EXPANSION       5'h06
`define OFS_NP_TX           5'h07
`define OFS_PARTNER_NP      5'h08
`define OFS_AUX_CTRL        5'h10
`define OFS_IRQ_STATUS      5'h18
`define OFS_IRQ_CLEAR       5'h19
`define OFS_IRQ_ENABLE      5'h1A

// Expansion register fields
`define EXP_PDF_BIT         4
`define EXP_PARTNER_NP_BIT  3
`define EXP_LOCAL_NP_BIT    2
`define EXP_PAGE_RX_BIT     1
`define EXP_NEG_CAP_BIT     0
`define EXP_RSVD_HI         15
`define EXP_RSVD_LO         5

// Next page word fields, shared by the outgoing and received pages
`define NP_MORE_BIT         15
`define NP_ACK_BIT          14
`define NP_MSG_BIT          13
`define NP_COMPLY_BIT       12
`define NP_TOGGLE_BIT       11
`define NP_CODE_HI          10
`define NP_CODE_LO          0

// Auxiliary control fields
`define AUX_SYM_BYPASS_BIT  7
`define AUX_FEF_BIT         5
`define AUX_EXT_FIFO_BIT    2
`define AUX_OOB_BIT         1

// Interrupt status, clear and enable layout
`define IRQ_PDF_BIT         0
`define IRQ_PAGE_BIT        1

// Reset values
`define NP_TX_RESET         16'h2001
`define PARTNER_NP_RESET    16'h0000
`define AUX_CTRL_RESET      16'h0000
`define IRQ_RESET           2'h0

`endif

// ===== autoneg_regs_pkg.sv
// Types shared by the auto-negotiation page and aux control register bank
`default_nettype none
package autoneg_regs_pkg;

    typedef logic [4:0]  reg_addr_t;
    typedef logic [15:0] reg_word_t;
    typedef logic [1:0]  irq_vec_t;

endpackage
`default_nettype wire

// ===== neg_engine_model.sv
// Negotiation engine and receive path model feeding events and partner status
`timescale 1ns/10ps
`default_nettype none
module neg_engine_model (
    // Clock
    input  wire logic                   i_clock,
    // Events and levels toward the register bank
    output logic                        o_par_det_fault,
    output logic                        o_page_rx,
    output autoneg_regs_pkg::reg_word_t o_page_rx_word,
    output logic                        o_partner_np_capable,
    output logic                        o_partner_neg_capable,
    output logic                        o_np_sent,
    output logic                        o_toggle_load,
    output logic                        o_toggle_val,
    output logic                        o_codec_bypass
);
    import autoneg_regs_pkg::*;

    initial begin
        o_par_det_fault = 1'b0;
        o_page_rx = 1'b0;
        o_page_rx_word = 16'h0000;
        o_partner_np_capable = 1'b0;
        o_partner_neg_capable = 1'b0;
        o_np_sent = 1'b0;
        o_toggle_load = 1'b0;
        o_toggle_val = 1'b0;
        o_codec_bypass = 1'b0;
    end

    task automatic set_levels(input logic np, input logic neg, input logic codec);
        @(posedge i_clock);
        o_partner_np_capable <= np;
        o_partner_neg_capable <= neg;
        o_codec_bypass <= codec;
    endtask

    task automatic pulse_fault();
        @(posedge i_clock);
        o_par_det_fault <= 1'b1;
        @(posedge i_clock);
        o_par_det_fault <= 1'b0;
    endtask

    // page pulsed only once checked; word is not held afterwards
    task automatic send_page(input reg_word_t w);
        @(posedge i_clock);
        o_page_rx <= 1'b1;
        o_page_rx_word <= w;
        @(posedge i_clock);
        o_page_rx <= 1'b0;
        o_page_rx_word <= ~w;
    endtask

    // arbitration flips the toggle per sent page, or loads it outright
    task automatic arbitrate(input logic load, input logic val);
        @(posedge i_clock);
        o_np_sent <= ~load;
        o_toggle_load <= load;
        o_toggle_val <= val;
        @(posedge i_clock);
        o_np_sent <= 1'b0;
        o_toggle_load <= 1'b0;
        o_toggle_val <= ~val;
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the auto-negotiation page and aux register bank
`timescale 1ns/10ps
`default_nettype none
`include "autoneg_regs_cfg.svh"
module tb;
    import autoneg_regs_pkg::*;
    logic      clock;
    logic      rst_n;
    reg_addr_t addr;
    reg_word_t wr_data;
    logic      wr_en;
    logic      rd_en;
    reg_word_t rd_data;
    logic      pdf, page_rx, np_cap, neg_cap, np_sent, tg_load, tg_val, codec;
    reg_word_t page_word;
    reg_word_t np_tx_word;
    logic      raw_5b, sym_byp, fef_en, ext_fifo, oob_en, irq;
    int        miscompares;
    int        n_compared;

    autoneg_page_aux_regs i_autoneg_page_aux_regs (
        .i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wr_data),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
        .i_par_det_fault(pdf), .i_page_rx(page_rx), .i_page_rx_word(page_word),
        .i_partner_np_capable(np_cap), .i_partner_neg_capable(neg_cap),
        .i_np_sent(np_sent), .i_toggle_load(tg_load), .i_toggle_val(tg_val),
        .i_codec_bypass(codec), .o_np_tx_word(np_tx_word), .o_raw_5b_mode(raw_5b),
        .o_sym_align_bypass(sym_byp), .o_far_end_fault_en(fef_en),
        .o_ext_fifo_en(ext_fifo), .o_reduced_mii_oob_en(oob_en), .o_irq(irq));

    neg_engine_model i_neg_engine_model (
        .i_clock(clock), .o_par_det_fault(pdf), .o_page_rx(page_rx),
        .o_page_rx_word(page_word), .o_partner_np_capable(np_cap),
        .o_partner_neg_capable(neg_cap), .o_np_sent(np_sent),
        .o_toggle_load(tg_load), .o_toggle_val(tg_val), .o_codec_bypass(codec));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input reg_word_t seen, input reg_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic wr(input reg_addr_t a, input reg_word_t d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input reg_addr_t a, output reg_word_t d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        d = rd_data;
    endtask

    task automatic rdchk(input reg_addr_t a, input reg_word_t exp, input string name);
        reg_word_t d;
        rd(a, d);
        check(name, d, exp);
    endtask

    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 8) begin
            @(negedge clock);
            n++;
        end
        check("irq", {15'h0000, irq}, {15'h0000, exp});
        if (irq !== exp) stop_test();
    endtask

    task automatic t_reset_values();
        rdchk(`OFS_EXPANSION, 16'h0004, "expansion reset");
        rdchk(`OFS_NP_TX, 16'h2001, "np tx reset");
        rdchk(`OFS_PARTNER_NP, 16'h0000, "partner np reset");
        rdchk(`OFS_AUX_CTRL, 16'h0000, "aux reset");
        check("np tx out", np_tx_word, 16'h2001);
        check("aux outs", {11'h000, raw_5b, sym_byp, fef_en, ext_fifo, oob_en}, 16'h0000);
        rdchk(5'h1F, 16'h0000, "unmapped");
    endtask

    task automatic t_flags();
        reg_word_t d;
        i_neg_engine_model.set_levels(1'b1, 1'b1, 1'b0);
        wr(`OFS_EXPANSION, 16'hFFFF);
        rdchk(`OFS_EXPANSION, 16'h000D, "expansion levels");
        i_neg_engine_model.pulse_fault();
        i_neg_engine_model.send_page(16'h9BCD);
        rdchk(`OFS_EXPANSION, 16'h001F, "expansion latched");
        rdchk(`OFS_EXPANSION, 16'h000D, "expansion cleared");
        rdchk(`OFS_PARTNER_NP, 16'h9BCD, "partner np");
        i_neg_engine_model.send_page(16'h67FF);
        wr(`OFS_PARTNER_NP, 16'h1000);
        rdchk(`OFS_PARTNER_NP, 16'h67FF, "partner np comply clear");
        // Both events land in the clearing read's cycle
        fork
            rd(`OFS_EXPANSION, d);
            i_neg_engine_model.pulse_fault();
            i_neg_engine_model.send_page(16'h67FF);
        join
        check("read before events", d, 16'h000F);
        rdchk(`OFS_EXPANSION, 16'h001F, "flag kept");
        fork
            i_neg_engine_model.pulse_fault();
            begin
                @(posedge clock);
                rd(`OFS_EXPANSION, d);
            end
        join
        check("fault then read", d, 16'h001D);
        i_neg_engine_model.set_levels(1'b0, 1'b0, 1'b0);
        rdchk(`OFS_EXPANSION, 16'h0004, "expansion no partner");
    endtask

    task automatic t_next_page();
        wr(`OFS_NP_TX, 16'hFFFF);
        rdchk(`OFS_NP_TX, 16'hF7FF, "np tx toggle ro");
        check("np tx out", np_tx_word, 16'hF7FF);
        i_neg_engine_model.arbitrate(1'b0, 1'b0);
        rdchk(`OFS_NP_TX, 16'hFFFF, "toggle flip");
        i_neg_engine_model.arbitrate(1'b1, 1'b0);
        wr(`OFS_NP_TX, 16'h0ABC);
        rdchk(`OFS_NP_TX, 16'h02BC, "np tx unformatted");
        check("np tx out last", np_tx_word, 16'h02BC);
    endtask

    task automatic t_aux();
        int bits[4] = '{7, 5, 2, 1};
        for (int i = 0; i < 4; i++) begin
            // reserved aux bits written as zero
            wr(`OFS_AUX_CTRL, 16'h0001 << bits[i]);
            settle(1);
            check("aux outs", {12'h000, sym_byp, fef_en, ext_fifo, oob_en}, 16'h0008 >> i);
            rdchk(`OFS_AUX_CTRL, 16'h0001 << bits[i], "aux readback");
        end
        check("raw 5b off", {15'h0000, raw_5b}, 16'h0000);
        i_neg_engine_model.set_levels(1'b0, 1'b0, 1'b1);
        wr(`OFS_AUX_CTRL, 16'h0080);
        settle(2);
        check("raw 5b on", {15'h0000, raw_5b}, 16'h0001);
        wr(`OFS_AUX_CTRL, 16'h0000);
        settle(2);
        check("raw 5b clr", {15'h0000, raw_5b}, 16'h0000);
    endtask

    task automatic t_irq();
        // Drop status left over from earlier scenarios
        wr(`OFS_IRQ_CLEAR, 16'h0003);
        wr(`OFS_IRQ_ENABLE, 16'h0003);
        i_neg_engine_model.pulse_fault();
        wait_irq(1'b1);
        rdchk(`OFS_IRQ_STATUS, 16'h0001, "irq status");
        wr(`OFS_IRQ_CLEAR, 16'h0001);
        wait_irq(1'b0);
        wr(`OFS_IRQ_ENABLE, 16'h0002);
        i_neg_engine_model.pulse_fault();
        settle(3);
        check("irq masked", {15'h0000, irq}, 16'h0000);
        i_neg_engine_model.send_page(16'h0001);
        wait_irq(1'b1);
        wr(`OFS_IRQ_CLEAR, 16'h0003);
        wait_irq(1'b0);
        rdchk(`OFS_IRQ_CLEAR, 16'h0000, "clear reads zero");
    endtask

    initial begin
        miscompares = 0;
        n_compared = 0;
        rst_n = 1'b0;
        addr = 5'h00;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset_values();
        t_flags();
        t_next_page();
        t_aux();
        t_irq();
        stop_test();
    end
endmodule
`default_nettype wire
